// File: include/cexd_pkg.sv
// Behaviour
// - Undefined primary opcode or undefined function-group function code is a bad opcode.
// - Undefined sub-opcode in bits 20..16 of branch-immediate group is a bad opcode.
// - Wide opcodes are bad in user mode without user_wide_enable, supervisor without supervisor_wide_enable.
// - Bad opcode writes bad_opcode_code into the exception code.
// - Return pc is the faulting pc, or the branch pc in a delay slot.
// - Copro instruction to an unusable unit faults; unit zero only when unmarked in user mode.
// - Copro fault sets its code and records the referenced unit in two bits.
// - Interrupt taken when a request is live and its request_mask_field bit set.
// - Clear global_request_gate blocks all eight requests together.
// - Interrupt sets its code; pending_request_bits shows live requests.
// - Two software requests held in writable bits, cleared by writing zero.
// - Loads or stores hitting the match address fault, per-type enables chosen.
// - Line-maintenance instructions never raise the address-match exception; a match held in watch_hold_ff is still taken at one.
// - Address match is deferred while exception_level_flag is set; no other mask.
// - Floating-point fault is unmaskable, sets float_fault_code, records reason bits.
// - Floating-point condition withdrawn once software clears the reason bits.
// - All exceptions use one common vector; bad opcode, copro and float unmasked.
// - Five active-low pins show in cause bits 14 down to 10.
// - delay_slot_flag set for a delay-slot instruction, cleared otherwise.
package cexd_pkg;
  localparam logic [4:0] EXC_INT = 5'h00;
  localparam logic [4:0] EXC_BAD_OP = 5'h0a;
  localparam logic [4:0] EXC_COP = 5'h0b;
  localparam logic [4:0] EXC_FLOAT = 5'h0f;
  localparam logic [4:0] EXC_MATCH = 5'h17;
  localparam logic [63:0] COMMON_VECTOR = 64'hffff_ffff_8000_0180;
  // Lookup masks: bit n set means code n is defined or wide
  localparam logic [63:0] PRIMARY_DEFINED = 64'hf7f7_ffff_0fff_ffff;
  localparam logic [63:0] FUNCT_DEFINED = 64'hdd5f_fcff_ffff_b3dd;
  localparam logic [31:0] BRIMM_DEFINED = 32'h000f_5f0f;
  localparam logic [63:0] PRIMARY_WIDE = 64'h9090_3080_0f00_0000;
  localparam logic [63:0] FUNCT_WIDE = 64'hdd00_f000_f0d0_0000;
  localparam logic [5:0] OP_FUNCT_GROUP = 6'h00;
  localparam logic [5:0] OP_BRANCH_IMM_GROUP = 6'h01;
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam logic [1:0] MODE_SUPER = 2'h1;
  localparam logic [1:0] MODE_USER = 2'h2;
  localparam int SW_REQ_LSB = 0;
  localparam int PIN_REQ_LSB = 2;
  localparam int TIMER_REQ_BIT = 7;
  localparam logic [1:0] SW_REQ_RESET = 2'h0;
  localparam logic [4:0] PIN_SYNC_RESET = 5'h1f;
  localparam logic [5:0] REASON_RESET = 6'h00;

  typedef enum logic [2:0] {K_NONE, K_INT, K_FLOAT, K_MATCH, K_BAD, K_COP} cexd_kind_t;

  typedef struct packed {
    logic global_request_gate;
    logic exception_level_flag;
    logic [1:0] mode;
    logic user_wide_enable;
    logic supervisor_wide_enable;
    logic [7:0] request_mask_field;
    logic [3:0] cop_usable;
  } cexd_status_t;

  typedef struct packed {
    logic valid;
    logic in_slot;
    logic [31:0] instr;
    logic [63:0] pc;
    logic [63:0] br_pc;
  } cexd_dec_t;

  typedef struct packed {
    logic valid;
    logic in_slot;
    logic is_load;
    logic is_store;
    logic is_line_maint;
    logic [35:0] paddr;
    logic [63:0] pc;
    logic [63:0] br_pc;
  } cexd_mem_t;

  typedef struct packed {
    logic [3:0] match_addr_high;
    logic [31:3] match_addr_low;
    logic en_load;
    logic en_store;
  } cexd_watch_t;

  function automatic logic lut64(input logic [63:0] mask, input logic [5:0] idx);
    lut64 = mask[idx];
  endfunction : lut64
endpackage : cexd_pkg

// File: verilog/cexd_opdec.sv
`timescale 1ns/1ps
`default_nettype none
module cexd_opdec (
  input wire logic [31:0] instr,
  input wire cexd_pkg::cexd_status_t status,
  output logic bad_op,
  output logic cop_unusable,
  output logic [1:0] cop_num
);
  import cexd_pkg::*;
  logic [5:0] op;
  logic [5:0] fn;
  logic [4:0] sub;
  logic wide;
  logic wide_ok;
  logic is_cop;
  assign op = instr[31:26];
  assign fn = instr[5:0];
  assign sub = instr[20:16];
  assign wide = lut64(PRIMARY_WIDE, op) || (op == OP_FUNCT_GROUP && lut64(FUNCT_WIDE, fn));
  assign wide_ok = !((status.mode == MODE_USER && !status.user_wide_enable) ||
                     (status.mode == MODE_SUPER && !status.supervisor_wide_enable));
  assign bad_op = !lut64(PRIMARY_DEFINED, op) ||
                  (op == OP_FUNCT_GROUP && !lut64(FUNCT_DEFINED, fn)) ||
                  (op == OP_BRANCH_IMM_GROUP && !BRIMM_DEFINED[sub]) ||
                  (wide && !wide_ok);
  assign is_cop = (op[5:2] == 4'h4) || (op[5:4] == 2'h3 && op[1:0] != 2'h0 && op[1:0] != 2'h3);
  assign cop_num = op[1:0];
  assign cop_unusable = is_cop && !status.cop_usable[cop_num] &&
                        (cop_num != 2'h0 || status.mode == MODE_USER);
endmodule : cexd_opdec
`default_nettype wire

// File: verilog/cexd_watch.sv
`timescale 1ns/1ps
`default_nettype none
module cexd_watch (
  input wire cexd_pkg::cexd_mem_t mem_in,
  input wire cexd_pkg::cexd_watch_t cfg,
  output logic hit
);
  import cexd_pkg::*;
  logic addr_eq;
  logic type_en;
  assign addr_eq = mem_in.paddr[35:3] == {cfg.match_addr_high, cfg.match_addr_low};
  assign type_en = (mem_in.is_load && cfg.en_load) || (mem_in.is_store && cfg.en_store);
  assign hit = mem_in.valid && addr_eq && type_en && !mem_in.is_line_maint;
endmodule : cexd_watch
`default_nettype wire

// File: verilog/cexd_unit.sv
`timescale 1ns/1ps
`default_nettype none
module cexd_unit (
  input wire logic clk,
  input wire logic nrst,
  input wire cexd_pkg::cexd_dec_t dec_in,
  input wire cexd_pkg::cexd_mem_t mem_in,
  input wire cexd_pkg::cexd_status_t status,
  input wire cexd_pkg::cexd_watch_t watch_cfg,
  input wire logic [4:0] ext_req_n,
  input wire logic timer_req,
  input wire logic sw_req_we,
  input wire logic [1:0] sw_req_wdata,
  input wire logic fpu_fault,
  input wire logic [5:0] fpu_reason,
  input wire logic fcsr_reason_we,
  input wire logic [5:0] fcsr_reason_wdata,
  output logic exc_take_ff,
  output logic flush_younger_ff,
  output logic [4:0] exc_code_ff,
  output logic [63:0] exception_return_pc_ff,
  output logic delay_slot_flag_ff,
  output logic [1:0] cop_err_ff,
  output logic [63:0] vector_pc_ff,
  output logic [7:0] pending_request_bits_ff,
  output logic [4:0] pin_view_ff,
  output logic [5:0] fcsr_reason_ff
);
  import cexd_pkg::*;

  // ==========================================================
  // Decoding helpers
  function automatic logic [4:0] kind_code(input cexd_kind_t k);
    unique case (k)
      K_INT: kind_code = EXC_INT;
      K_FLOAT: kind_code = EXC_FLOAT;
      K_MATCH: kind_code = EXC_MATCH;
      K_BAD: kind_code = EXC_BAD_OP;
      K_COP: kind_code = EXC_COP;
      default: kind_code = EXC_INT;
    endcase
  endfunction : kind_code

  function automatic logic from_mem(input cexd_kind_t k);
    from_mem = (k == K_INT) || (k == K_FLOAT) || (k == K_MATCH);
  endfunction : from_mem

  // ==========================================================
  // Internal signals
  logic bad_op;
  logic cop_unusable;
  logic [1:0] cop_num;
  logic watch_hit;
  logic watch_due;
  logic int_req;
  logic [7:0] int_live;
  cexd_kind_t kind;
  logic [4:0] pin_meta_ff;
  logic [4:0] pin_sync_ff;
  logic [1:0] sw_req_ff;
  logic watch_hold_ff;
  logic fp_req_ff;
  logic [1:0] nxt_sw_req;
  logic [5:0] nxt_reason;
  logic [63:0] nxt_epc;
  logic nxt_slot;

  // ==========================================================
  // Sub-blocks
  cexd_opdec u_opdec (
    .instr(dec_in.instr),
    .status(status),
    .bad_op(bad_op),
    .cop_unusable(cop_unusable),
    .cop_num(cop_num)
  );

  cexd_watch u_watch (
    .mem_in(mem_in),
    .cfg(watch_cfg),
    .hit(watch_hit)
  );

  // ==========================================================
  // Pin synchroniser
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_meta_ff <= PIN_SYNC_RESET;
      pin_sync_ff <= PIN_SYNC_RESET;
    end else begin
      pin_meta_ff <= ext_req_n;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ==========================================================
  // Software requests
  always_comb begin
    nxt_sw_req = sw_req_ff;
    if (sw_req_we) begin
      nxt_sw_req = sw_req_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sw_req_ff <= SW_REQ_RESET;
    end else begin
      sw_req_ff <= nxt_sw_req;
    end
  end

  // ==========================================================
  // Interrupt request view
  // pins follow the wire only
  always_comb begin
    int_live = 8'h00;
    int_live[SW_REQ_LSB +: 2] = sw_req_ff;
    int_live[PIN_REQ_LSB +: 5] = ~pin_sync_ff;
    int_live[TIMER_REQ_BIT] = timer_req;
  end

  assign int_req = status.global_request_gate && (|(int_live & status.request_mask_field));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pending_request_bits_ff <= 8'h00;
      pin_view_ff <= 5'h00;
    end else begin
      pending_request_bits_ff <= int_live;
      pin_view_ff <= ~pin_sync_ff;
    end
  end

  // ==========================================================
  // Floating-point reason and request
  always_comb begin
    nxt_reason = fcsr_reason_ff;
    if (fcsr_reason_we) begin
      nxt_reason = fcsr_reason_wdata;
    end
    if (fpu_fault) begin
      nxt_reason = nxt_reason | fpu_reason;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fcsr_reason_ff <= REASON_RESET;
    end else begin
      fcsr_reason_ff <= nxt_reason;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fp_req_ff <= 1'b0;
    end else if (fpu_fault) begin
      fp_req_ff <= 1'b1;
    end else if (kind == K_FLOAT) begin
      fp_req_ff <= 1'b0;
    end else if (fcsr_reason_we && fcsr_reason_wdata == 6'h00) begin
      fp_req_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Address-match deferral
  // held while level flag set
  assign watch_due = (watch_hit || watch_hold_ff) && !status.exception_level_flag;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      watch_hold_ff <= 1'b0;
    end else if (watch_hit && status.exception_level_flag) begin
      watch_hold_ff <= 1'b1;
    end else if (kind == K_MATCH) begin
      watch_hold_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Priority select
  always_comb begin
    kind = K_NONE;
    if (mem_in.valid && int_req) begin
      kind = K_INT;
    end else if (mem_in.valid && fp_req_ff) begin
      kind = K_FLOAT;
    end else if (mem_in.valid && watch_due) begin
      kind = K_MATCH;
    end else if (dec_in.valid && bad_op) begin
      kind = K_BAD;
    end else if (dec_in.valid && cop_unusable) begin
      kind = K_COP;
    end
  end

  always_comb begin
    if (from_mem(kind)) begin
      nxt_slot = mem_in.in_slot;
      nxt_epc = mem_in.in_slot ? mem_in.br_pc : mem_in.pc;
    end else begin
      nxt_slot = dec_in.in_slot;
      nxt_epc = dec_in.in_slot ? dec_in.br_pc : dec_in.pc;
    end
  end

  // ==========================================================
  // Report registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      exc_take_ff <= 1'b0;
      flush_younger_ff <= 1'b0;
    end else begin
      exc_take_ff <= kind != K_NONE;
      flush_younger_ff <= kind != K_NONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      exc_code_ff <= EXC_INT;
      exception_return_pc_ff <= 64'h0;
      delay_slot_flag_ff <= 1'b0;
      vector_pc_ff <= COMMON_VECTOR;
    end else if (kind != K_NONE) begin
      exc_code_ff <= kind_code(kind);
      exception_return_pc_ff <= nxt_epc;
      delay_slot_flag_ff <= nxt_slot;
      vector_pc_ff <= COMMON_VECTOR;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cop_err_ff <= 2'h0;
    end else if (kind == K_COP) begin
      cop_err_ff <= cop_num;
    end
  end

  // ==========================================================
  // Checks
  property p_bad_code;
    @(posedge clk) disable iff (!nrst)
      (dec_in.valid && bad_op && !mem_in.valid) |=> (exc_take_ff && exc_code_ff == EXC_BAD_OP);
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad opcode not reported");

  property p_cop;
    @(posedge clk) disable iff (!nrst)
      (dec_in.valid && !bad_op && cop_unusable && !mem_in.valid)
        |=> (exc_code_ff == EXC_COP && cop_err_ff == $past(dec_in.instr[27:26]));
  endproperty
  a_cop: assert property (p_cop) else $error("copro fault code or unit wrong");

  property p_gate;
    @(posedge clk) disable iff (!nrst)
      !status.global_request_gate |=> !(exc_take_ff && exc_code_ff == EXC_INT);
  endproperty
  a_gate: assert property (p_gate) else $error("interrupt taken with gate clear");

  property p_int_mask;
    @(posedge clk) disable iff (!nrst)
      (mem_in.valid && status.global_request_gate && |(int_live & status.request_mask_field))
        |=> (exc_take_ff && exc_code_ff == EXC_INT);
  endproperty
  a_int_mask: assert property (p_int_mask) else $error("masked-in request not taken");

  property p_sw_clear;
    @(posedge clk) disable iff (!nrst)
      (sw_req_we && sw_req_wdata == 2'h0) |=> ##1 (pending_request_bits_ff[1:0] == 2'h0);
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("software request not cleared");

  property p_pin_view;
    @(posedge clk) disable iff (!nrst)
      ($past(nrst, 3) && nrst) |-> (pin_view_ff == ~$past(ext_req_n, 3));
  endproperty
  a_pin_view: assert property (p_pin_view) else $error("pin view does not follow pins");

  property p_no_maint;
    @(posedge clk) disable iff (!nrst)
      (mem_in.valid && mem_in.is_line_maint && !watch_hold_ff) |=> !(exc_take_ff && exc_code_ff == EXC_MATCH);
  endproperty
  a_no_maint: assert property (p_no_maint) else $error("match raised on line maintenance");

  property p_match_defer;
    @(posedge clk) disable iff (!nrst)
      status.exception_level_flag |=> !(exc_take_ff && exc_code_ff == EXC_MATCH);
  endproperty
  a_match_defer: assert property (p_match_defer) else $error("match taken at exception level");

  property p_slot_epc;
    @(posedge clk) disable iff (!nrst)
      (mem_in.valid && (int_req || fp_req_ff || watch_due))
        |=> (delay_slot_flag_ff == $past(mem_in.in_slot) &&
             exception_return_pc_ff == ($past(mem_in.in_slot) ? $past(mem_in.br_pc) : $past(mem_in.pc)));
  endproperty
  a_slot_epc: assert property (p_slot_epc) else $error("delay slot return pc wrong");

  property p_fp_withdraw;
    @(posedge clk) disable iff (!nrst)
      (fcsr_reason_we && fcsr_reason_wdata == 6'h00 && !fpu_fault) |=> !fp_req_ff;
  endproperty
  a_fp_withdraw: assert property (p_fp_withdraw) else $error("float request not withdrawn");

  property p_fp_take;
    @(posedge clk) disable iff (!nrst)
      (fp_req_ff && mem_in.valid && !int_req) |=> (exc_take_ff && exc_code_ff == EXC_FLOAT);
  endproperty
  a_fp_take: assert property (p_fp_take) else $error("float fault not taken");

  property p_oldest;
    @(posedge clk) disable iff (!nrst)
      (mem_in.valid && int_req && dec_in.valid && bad_op) |=> (exc_code_ff == EXC_INT && flush_younger_ff);
  endproperty
  a_oldest: assert property (p_oldest) else $error("younger exception reported first");

  property p_vector;
    @(posedge clk) disable iff (!nrst)
      exc_take_ff |-> (vector_pc_ff == COMMON_VECTOR);
  endproperty
  a_vector: assert property (p_vector) else $error("vector not common");

  c_int: cover property (@(posedge clk) disable iff (!nrst) exc_take_ff && exc_code_ff == EXC_INT);
  c_match: cover property (@(posedge clk) disable iff (!nrst) exc_take_ff && exc_code_ff == EXC_MATCH);
  c_float: cover property (@(posedge clk) disable iff (!nrst) exc_take_ff && exc_code_ff == EXC_FLOAT);
  c_bad_slot: cover property (@(posedge clk) disable iff (!nrst)
    exc_take_ff && exc_code_ff == EXC_BAD_OP && delay_slot_flag_ff);
endmodule : cexd_unit
`default_nettype wire

// File: dv/cexd_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module cexd_far_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [4:0] raise_pins,
  input wire logic raise_timer,
  input wire logic exc_take,
  input wire logic [4:0] exc_code,
  output logic [4:0] ext_req_n,
  output logic timer_req
);
  import cexd_pkg::*;
  // ==========================================
  // Interrupt sources
  // pin held until serviced
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_req_n <= 5'h1f;
      timer_req <= 1'h0;
    end else if (exc_take && exc_code == EXC_INT) begin
      // Handler services every source, lines return to pulled-up idle
      ext_req_n <= 5'h1f;
      timer_req <= 1'h0;
    end else begin
      ext_req_n <= ext_req_n & ~raise_pins;
      timer_req <= timer_req | raise_timer;
    end
  end
endmodule : cexd_far_model
`default_nettype wire

// File: dv/test_cexd_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_cexd_unit;
  import cexd_pkg::*;
  typedef struct packed {
    logic [4:0] code;
    logic [63:0] exception_return_pc;
    logic slot;
    logic [1:0] cop;
  } cexd_exp_t;
  logic clk, nrst, sw_req_we, fpu_fault, fcsr_reason_we, raise_timer, timer_req;
  logic exc_take_ff, flush_younger_ff, delay_slot_flag_ff;
  logic [1:0] sw_req_wdata, cop_err_ff, last_cop;
  logic [4:0] ext_req_n, raise_pins, exc_code_ff, pin_view_ff;
  logic [5:0] fpu_reason, fcsr_reason_wdata, fcsr_reason_ff;
  logic [7:0] pending_request_bits_ff;
  logic [63:0] exception_return_pc_ff, vector_pc_ff;
  logic [31:0] seed;
  logic [35:0] pa;
  cexd_dec_t dec_in;
  cexd_mem_t mem_in;
  cexd_status_t status;
  cexd_watch_t watch_cfg;
  cexd_exp_t exp_q[$];
  int fails, checks;

  cexd_unit cexd_unit_inst (.clk(clk), .nrst(nrst), .dec_in(dec_in), .mem_in(mem_in), .status(status),
    .watch_cfg(watch_cfg), .ext_req_n(ext_req_n), .timer_req(timer_req), .sw_req_we(sw_req_we),
    .sw_req_wdata(sw_req_wdata), .fpu_fault(fpu_fault), .fpu_reason(fpu_reason),
    .fcsr_reason_we(fcsr_reason_we), .fcsr_reason_wdata(fcsr_reason_wdata), .exc_take_ff(exc_take_ff),
    .flush_younger_ff(flush_younger_ff), .exc_code_ff(exc_code_ff),
    .exception_return_pc_ff(exception_return_pc_ff), .delay_slot_flag_ff(delay_slot_flag_ff),
    .cop_err_ff(cop_err_ff), .vector_pc_ff(vector_pc_ff), .pending_request_bits_ff(pending_request_bits_ff),
    .pin_view_ff(pin_view_ff), .fcsr_reason_ff(fcsr_reason_ff));
  cexd_far_model cexd_far_model_inst (.clk(clk), .nrst(nrst), .raise_pins(raise_pins),
    .raise_timer(raise_timer), .exc_take(exc_take_ff), .exc_code(exc_code_ff), .ext_req_n(ext_req_n),
    .timer_req(timer_req));

  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic cmp_bits(input logic [63:0] got, input logic [63:0] want);
    checks++;
    if (got !== want) begin
      fails++;
      $display("Error at %0t: value %h expected %h", $time, got, want);
    end
  endtask : cmp_bits

  task automatic cmp_exc(input cexd_exp_t got, input cexd_exp_t want);
    checks++;
    if (got !== want) begin
      fails++;
      $display("Error at %0t: exception %h expected %h", $time, got, want);
    end
  endtask : cmp_exc

  task automatic dec_op(input logic [31:0] ins, input logic f, input logic [4:0] code, input logic [1:0] cop);
    logic [31:0] r;
    r = rnd();
    dec_in = '{1'b1, r[0], ins, {32'h0, r}, {32'h0, r} - 64'h4};
    if (f) begin
      if (code == EXC_COP) last_cop = cop;
      exp_q.push_back('{code, r[0] ? {32'h0, r} - 64'h4 : {32'h0, r}, r[0], last_cop});
    end
    cyc(1);
    dec_in.valid = 1'b0;
    cyc(2);
  endtask : dec_op

  task automatic mem_op(input logic [2:0] lsm, input logic [35:0] a, input logic f, input logic [4:0] code);
    logic [31:0] r;
    r = rnd();
    mem_in = '{1'b1, r[0], lsm[2], lsm[1], lsm[0], a, {32'h0, r}, {32'h0, r} - 64'h8};
    if (f) exp_q.push_back('{code, r[0] ? {32'h0, r} - 64'h8 : {32'h0, r}, r[0], last_cop});
    cyc(1);
    mem_in.valid = 1'b0;
    dec_in.valid = 1'b0;
    cyc(2);
  endtask : mem_op

  task automatic pulse_fault(input logic [5:0] why);
    fpu_fault = 1'b1;
    fpu_reason = why;
    cyc(1);
    fpu_fault = 1'b0;
  endtask : pulse_fault

  task automatic sw_write(input logic [1:0] v);
    sw_req_we = 1'b1;
    sw_req_wdata = v;
    cyc(1);
    sw_req_we = 1'b0;
    cyc(1);
  endtask : sw_write

  task automatic end_of_test();
    if (exp_q.size() != 0) begin
      fails++;
      $display("Error at %0t: %0d exceptions never taken", $time, exp_q.size());
    end
    $display("Checks %0d, errors %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ==========================================
  // Result watcher
  always @(negedge clk) begin
    if (nrst === 1'b1 && exc_take_ff !== 1'b0) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("Error at %0t: unexpected exception", $time);
      end else begin
        cmp_exc({exc_code_ff, exception_return_pc_ff, delay_slot_flag_ff, cop_err_ff}, exp_q.pop_front());
      end
      cmp_bits(vector_pc_ff, COMMON_VECTOR);
      cmp_bits(64'(flush_younger_ff), 64'h1);
    end
  end

  // ==========================================
  // Clock, watchdog, main sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    seed = 32'h5d;
    nrst = 1'b0;
    dec_in = '0;
    mem_in = '0;
    status = '0;
    watch_cfg = '0;
    sw_req_we = 1'b0;
    sw_req_wdata = 2'h0;
    fpu_fault = 1'b0;
    fpu_reason = 6'h00;
    fcsr_reason_we = 1'b0;
    fcsr_reason_wdata = 6'h00;
    raise_pins = 5'h00;
    raise_timer = 1'b0;
    last_cop = 2'h0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    cyc(1);
    dec_op(32'h7000_0000, 1'b1, EXC_BAD_OP, 2'h0);
    dec_op(32'h0000_0001, 1'b1, EXC_BAD_OP, 2'h0);
    dec_op(32'h0000_0020, 1'b0, EXC_BAD_OP, 2'h0);
    dec_op(32'h0404_0000, 1'b1, EXC_BAD_OP, 2'h0);
    dec_op(32'h0401_0000, 1'b0, EXC_BAD_OP, 2'h0);
    dec_op(32'h6000_0000, 1'b0, EXC_BAD_OP, 2'h0);
    dec_op(32'h4400_0000, 1'b1, EXC_COP, 2'h1);
    dec_op(32'h4800_0000, 1'b1, EXC_COP, 2'h2);
    dec_op(32'h4000_0000, 1'b0, EXC_COP, 2'h0);
    status.mode = MODE_USER;
    dec_op(32'h6000_0000, 1'b1, EXC_BAD_OP, 2'h0);
    dec_op(32'h4000_0000, 1'b1, EXC_COP, 2'h0);
    status.user_wide_enable = 1'b1;
    status.cop_usable = 4'h2;
    dec_op(32'h6000_0000, 1'b0, EXC_BAD_OP, 2'h0);
    dec_op(32'h4400_0000, 1'b0, EXC_COP, 2'h0);
    dec_op(32'hc800_0000, 1'b1, EXC_COP, 2'h2);
    status.mode = MODE_SUPER;
    dec_op(32'h6000_0000, 1'b1, EXC_BAD_OP, 2'h0);
    status.supervisor_wide_enable = 1'b1;
    dec_op(32'h6000_0000, 1'b0, EXC_BAD_OP, 2'h0);
    pa = {4'h9, rnd()};
    watch_cfg = '{pa[35:32], pa[31:3], 1'b1, 1'b0};
    mem_op(3'h4, pa ^ 36'h5, 1'b1, EXC_MATCH);
    mem_op(3'h4, pa ^ 36'h40, 1'b0, EXC_MATCH);
    mem_op(3'h2, pa, 1'b0, EXC_MATCH);
    watch_cfg.en_store = 1'b1;
    mem_op(3'h2, pa, 1'b1, EXC_MATCH);
    mem_op(3'h5, pa, 1'b0, EXC_MATCH);
    status.exception_level_flag = 1'b1;
    mem_op(3'h4, pa, 1'b0, EXC_MATCH);
    status.exception_level_flag = 1'b0;
    mem_op(3'h4, pa ^ 36'h40, 1'b1, EXC_MATCH);
    mem_op(3'h4, pa ^ 36'h40, 1'b0, EXC_MATCH);
    pulse_fault(6'h08);
    cmp_bits(64'(fcsr_reason_ff), 64'h08);
    mem_op(3'h0, pa, 1'b1, EXC_FLOAT);
    mem_op(3'h0, pa, 1'b0, EXC_FLOAT);
    pulse_fault(6'h01);
    fcsr_reason_we = 1'b1;
    fcsr_reason_wdata = 6'h00;
    cyc(1);
    fcsr_reason_we = 1'b0;
    cmp_bits(64'(fcsr_reason_ff), 64'h00);
    mem_op(3'h0, pa, 1'b0, EXC_FLOAT);
    pulse_fault(6'h02);
    dec_in = '{1'b1, 1'b0, 32'h7000_0000, 64'h100, 64'h0fc};
    mem_op(3'h0, pa, 1'b1, EXC_FLOAT);
    status.global_request_gate = 1'b1;
    status.request_mask_field = 8'h01;
    sw_write(2'h1);
    cmp_bits(64'(pending_request_bits_ff), 64'h01);
    dec_in = '{1'b1, 1'b1, 32'h0000_0001, 64'h200, 64'h1fc};
    mem_op(3'h0, pa, 1'b1, EXC_INT);
    status.global_request_gate = 1'b0;
    mem_op(3'h0, pa, 1'b0, EXC_INT);
    status.global_request_gate = 1'b1;
    status.request_mask_field = 8'h02;
    mem_op(3'h0, pa, 1'b0, EXC_INT);
    sw_write(2'h0);
    cmp_bits(64'(pending_request_bits_ff), 64'h00);
    status.request_mask_field = 8'h01;
    mem_op(3'h0, pa, 1'b0, EXC_INT);
    raise_pins = 5'h04;
    cyc(1);
    raise_pins = 5'h00;
    cyc(4);
    cmp_bits(64'(pin_view_ff), 64'h04);
    sw_write(2'h0);
    cmp_bits(64'(pending_request_bits_ff), 64'h10);
    status.request_mask_field = 8'h10;
    mem_op(3'h0, pa, 1'b1, EXC_INT);
    cyc(4);
    cmp_bits(64'(pin_view_ff), 64'h00);
    status.request_mask_field = 8'h80;
    status.global_request_gate = 1'b0;
    raise_timer = 1'b1;
    cyc(1);
    raise_timer = 1'b0;
    cyc(1);
    mem_op(3'h0, pa, 1'b0, EXC_INT);
    status.global_request_gate = 1'b1;
    mem_op(3'h0, pa, 1'b1, EXC_INT);
    cyc(4);
    end_of_test();
  end
endmodule : test_cexd_unit
`default_nettype wire
